// *** fsdo_cfg_if.sv ***
// interface: staged fail-safe settings and commit pulse passed from the register file to the supervisor
`timescale 1ns/100ps
`default_nettype none
interface fsdo_cfg_if;
  logic [7:0] kind;
  logic [7:0] bitmap;
  logic [7:0] delay;
  logic       commit;   // one-cycle transfer pulse

  modport src (output kind, output bitmap, output delay, output commit);
  modport dst (input kind, input bitmap, input delay, input commit);
endinterface
`default_nettype wire

// *** fsdo_host_model.sv ***
// host model: axi4-lite master standing in for the remote host controller
`timescale 1ns/100ps
`default_nettype none
module fsdo_host_model (
  // clock
  input  wire logic        clk,
  // write address and data
  output var logic [7:0]   s_axi_awaddr,
  output var logic         s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var logic [31:0]  s_axi_wdata,
  output var logic [3:0]   s_axi_wstrb,
  output var logic         s_axi_wvalid,
  input  wire logic        s_axi_wready,
  // write response
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var logic         s_axi_bready,
  // read address and data
  output var logic [7:0]   s_axi_araddr,
  output var logic         s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var logic         s_axi_rready
);
  // idle bus at time zero
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        got = 1'b1;
        resp = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
    // one spare edge so a following call never re-drives bready in this step
    @(posedge clk);
  endtask

  // one read; rready held until the data is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = 1'b1;
        d = s_axi_rdata;
        resp = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** fsdo_pkg.sv ***
// package: register map, field layout, reset values and timing for the fail-safe output port
package fsdo_pkg;

  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_OUTPUT_POINTS    = 8'h00;
  localparam logic [7:0] ADDR_FAILSAFE_KIND    = 8'h04;
  localparam logic [7:0] ADDR_FAILSAFE_BITMAP  = 8'h08;
  localparam logic [7:0] ADDR_FAILSAFE_DELAY   = 8'h0c;
  localparam logic [7:0] ADDR_FAILSAFE_COMMIT  = 8'h10;
  localparam logic [7:0] ADDR_BITMAP_POINT     = 8'h14;
  localparam logic [7:0] ADDR_STATUS           = 8'h18;
  localparam logic [7:0] ADDR_SUPERVISION      = 8'h1c;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int COMMIT_BIT       = 0;
  localparam int PT_LEVEL_BIT     = 8;   // per-point bitmap write: level in bit 8
  localparam int ST_FAILSAFE_BIT  = 0;
  localparam int ST_LOST_BIT      = 1;
  localparam int ST_KIND_LSB      = 8;
  localparam int ST_DELAY_LSB     = 16;

  // ---------------------------------------------------------------------------
  // reset values and kind codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_OUTPUT_POINTS = 8'h00;
  localparam logic [7:0]  RST_KIND          = 8'h01;
  localparam logic [7:0]  RST_BITMAP        = 8'h00;
  localparam logic [7:0]  RST_DELAY         = 8'h00;
  localparam logic [31:0] RST_SUPERVISION   = 32'h0773_5940; // 1 s of clocks
  localparam logic [7:0]  KIND_ALL_OFF      = 8'h01;
  localparam logic [7:0]  KIND_BITMAP       = 8'h02;
  localparam logic [7:0]  KIND_HOLD         = 8'h03;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam longint CLK_HZ         = 125_000_000;
  localparam longint TICK_TIME_MS   = 100;
  localparam longint TICK_CYCLES    = (CLK_HZ * TICK_TIME_MS) / 1000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // supervisor states
  typedef enum logic [2:0] {
    SV_LINKED = 3'b001,
    SV_DELAY  = 3'b010,
    SV_SAFE   = 3'b100
  } fsdo_sv_t;

endpackage

// *** fsdo_port.sv ***
// module: eight-point output port with fail-safe supervisor behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RL1] Software reads and writes all eight points as one byte, bit n drives point n.
// [RL2] Losing host communication leads to the fail-safe output state.
// [RL3] Kind 1 forces all off, kind 2 applies the bitmap, kind 3 holds the last state.
// [RL4] The bitmap is applied only for kind 2, a one bit turning its point on.
// [RL5] The bitmap can be written whole or one point at a time.
// [RL6] The delay setting counts tenths of a second.
// [RL7] Delay 0 engages at once, 1 gives 0.1 s, 255 gives 25.5 s.
// [RL8] The delay runs from loss of communication and fail-safe engages only after it.
// [RL9] Kind, bitmap and delay stay staged until the host writes the commit flag true.
// [RL10] The commit flag clears itself after transfer and a false write does nothing.
// [RL11] A prescaler makes the tenth-second tick and the count restarts when the host returns.
// [RL12] Loss means no valid host access for the supervision timeout; a host write leaves it.
module fsdo_port #(
  parameter longint TICK_CYCLES = fsdo_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // output points
  output logic [7:0]       points,
  output logic             failsafe_active
);

  fsdo_cfg_if cfg ();

  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        do_write;
  logic [7:0]  output_points;
  logic [7:0]  failsafe_kind;
  logic [7:0]  failsafe_bitmap;
  logic [7:0]  failsafe_delay;
  logic        failsafe_commit;
  logic [31:0] supervision;
  logic [31:0] idle_cnt;
  logic        comm_lost;
  logic        in_failsafe;
  logic [7:0]  act_kind;
  logic [7:0]  act_bitmap;
  logic [7:0]  act_delay;
  logic [7:0]  next_points;

  // known register address check, used by both read and write paths
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= fsdo_pkg::ADDR_SUPERVISION);
  endfunction

  // ---------------------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held       <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held       <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // write response, slverr for unmapped addresses
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fsdo_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok(aw_addr) ? fsdo_pkg::RESP_OKAY : fsdo_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // register file; only the byte lane 0 strobe is checked, though supervision takes all 32 bits and the point level is bit 8
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      output_points   <= fsdo_pkg::RST_OUTPUT_POINTS;
      failsafe_kind   <= fsdo_pkg::RST_KIND;
      failsafe_bitmap <= fsdo_pkg::RST_BITMAP;
      failsafe_delay  <= fsdo_pkg::RST_DELAY;
      supervision     <= fsdo_pkg::RST_SUPERVISION;
    end else if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        fsdo_pkg::ADDR_OUTPUT_POINTS:   output_points   <= w_data[7:0]; // [RL1]
        fsdo_pkg::ADDR_FAILSAFE_KIND:   failsafe_kind   <= w_data[7:0]; // [RL9]
        fsdo_pkg::ADDR_FAILSAFE_BITMAP: failsafe_bitmap <= w_data[7:0]; // [RL5]
        fsdo_pkg::ADDR_FAILSAFE_DELAY:  failsafe_delay  <= w_data[7:0]; // [RL9]
        fsdo_pkg::ADDR_BITMAP_POINT: begin
          // point index in bits 2:0, its level in bit 8
          failsafe_bitmap[w_data[2:0]] <= w_data[fsdo_pkg::PT_LEVEL_BIT]; // [RL5]
        end
        fsdo_pkg::ADDR_SUPERVISION:     supervision     <= w_data;
        default: ;
      endcase
    end
  end

  // commit pulse: true writes transfer, false writes do nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      failsafe_commit <= 1'b0;
    end else begin
      failsafe_commit <= do_write && w_strb[0] &&
                         aw_addr == fsdo_pkg::ADDR_FAILSAFE_COMMIT &&
                         w_data[fsdo_pkg::COMMIT_BIT]; // [RL10]
    end
  end

  assign cfg.kind   = failsafe_kind;
  assign cfg.bitmap = failsafe_bitmap;
  assign cfg.delay  = failsafe_delay;
  assign cfg.commit = failsafe_commit;

  // ---------------------------------------------------------------------------
  // read channel, one cycle answer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= fsdo_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= addr_ok(s_axi_araddr) ? fsdo_pkg::RESP_OKAY : fsdo_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        fsdo_pkg::ADDR_OUTPUT_POINTS: s_axi_rdata <= {24'h00_0000, points}; // [RL1]
        fsdo_pkg::ADDR_STATUS: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rdata[fsdo_pkg::ST_FAILSAFE_BIT]   <= in_failsafe;
          s_axi_rdata[fsdo_pkg::ST_LOST_BIT]       <= comm_lost;
          s_axi_rdata[fsdo_pkg::ST_KIND_LSB +: 8]  <= act_kind;
          s_axi_rdata[fsdo_pkg::ST_DELAY_LSB +: 8] <= act_delay;
        end
        fsdo_pkg::ADDR_SUPERVISION:   s_axi_rdata <= supervision;
        // settings registers are write-only and read as zero
        default:                      s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // link supervision: any accepted host access restarts the idle count
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || do_write || (s_axi_arvalid && s_axi_arready)) begin // [RL12]
      idle_cnt  <= 32'h0000_0000;
      comm_lost <= 1'b0;
    end else if (idle_cnt >= supervision) begin
      comm_lost <= 1'b1; // [RL12]
    end else begin
      idle_cnt  <= idle_cnt + 32'h0000_0001;
    end
  end

  fsdo_supervisor #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_sup (
    .clk         (clk),
    .srst        (srst),
    .cfg         (cfg),
    .comm_lost   (comm_lost),
    .host_write  (do_write),
    .in_failsafe (in_failsafe),
    .act_kind    (act_kind),
    .act_bitmap  (act_bitmap),
    .act_delay   (act_delay)
  );

  // ---------------------------------------------------------------------------
  // output select; an unknown kind falls back to all off as the safer choice
  // ---------------------------------------------------------------------------
  always_comb begin
    next_points = output_points; // [RL1]
    if (in_failsafe) begin // [RL2]
      if (act_kind == fsdo_pkg::KIND_BITMAP) begin
        next_points = act_bitmap; // [RL4]
      end else if (act_kind == fsdo_pkg::KIND_HOLD) begin
        next_points = points; // [RL3]
      end else begin
        next_points = 8'h00; // [RL3]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      points          <= fsdo_pkg::RST_OUTPUT_POINTS;
      failsafe_active <= 1'b0;
    end else begin
      points          <= next_points;
      failsafe_active <= in_failsafe;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_points_follow: assert property (@(posedge clk) disable iff (srst) // [RL1]
    !in_failsafe |=> points == $past(output_points))
    else $error("points do not follow written value");
  a_kind_off: assert property (@(posedge clk) disable iff (srst) // [RL3]
    (in_failsafe && act_kind == fsdo_pkg::KIND_ALL_OFF) |=> points == 8'h00)
    else $error("kind 1 did not force all off");
  a_kind_bitmap: assert property (@(posedge clk) disable iff (srst) // [RL4]
    (in_failsafe && act_kind == fsdo_pkg::KIND_BITMAP) |=> points == $past(act_bitmap))
    else $error("kind 2 did not apply bitmap");
  a_kind_hold: assert property (@(posedge clk) disable iff (srst) // [RL3]
    (in_failsafe && act_kind == fsdo_pkg::KIND_HOLD) |=> $stable(points))
    else $error("kind 3 did not hold outputs");
  a_commit_pulse: assert property (@(posedge clk) disable iff (srst) // [RL10]
    failsafe_commit |=> !failsafe_commit)
    else $error("commit flag did not clear itself");
  a_false_commit: assert property (@(posedge clk) disable iff (srst) // [RL10]
    (do_write && aw_addr == fsdo_pkg::ADDR_FAILSAFE_COMMIT && !w_data[fsdo_pkg::COMMIT_BIT])
      |=> !failsafe_commit)
    else $error("false commit write caused a transfer");
  a_true_commit: assert property (@(posedge clk) disable iff (srst) // [RL9]
    (do_write && w_strb[0] && aw_addr == fsdo_pkg::ADDR_FAILSAFE_COMMIT &&
     w_data[fsdo_pkg::COMMIT_BIT]) |=> failsafe_commit)
    else $error("true commit write did not transfer");
  a_points_written: assert property (@(posedge clk) disable iff (srst) // [RL1]
    (do_write && w_strb[0] && aw_addr == fsdo_pkg::ADDR_OUTPUT_POINTS)
      |=> output_points == $past(w_data[7:0]))
    else $error("point byte write did not land");
  a_point_level: assert property (@(posedge clk) disable iff (srst) // [RL5]
    (do_write && w_strb[0] && aw_addr == fsdo_pkg::ADDR_BITMAP_POINT)
      |=> failsafe_bitmap[$past(w_data[2:0])] == $past(w_data[fsdo_pkg::PT_LEVEL_BIT]))
    else $error("per-point bitmap write did not land");
  a_loss_timeout: assert property (@(posedge clk) disable iff (srst) // [RL12]
    (!do_write && !(s_axi_arvalid && s_axi_arready) && idle_cnt >= supervision)
      |=> comm_lost)
    else $error("idle timeout did not flag loss");
  a_access_clears: assert property (@(posedge clk) disable iff (srst) // [RL12]
    (do_write || (s_axi_arvalid && s_axi_arready)) |=> !comm_lost && idle_cnt == 32'h0000_0000)
    else $error("host access did not restart supervision");
  a_active_follows: assert property (@(posedge clk) disable iff (srst) // [RL2]
    in_failsafe |=> failsafe_active)
    else $error("fail-safe state not shown on output");
  a_bresp_stands: assert property (@(posedge clk) disable iff (srst) // [RL1]
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_stands: assert property (@(posedge clk) disable iff (srst) // [RL1]
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

endmodule
`default_nettype wire

// *** fsdo_supervisor.sv ***
// module: committed settings store, tenth-second prescaler and fail-safe delay supervisor
`timescale 1ns/100ps
`default_nettype none
module fsdo_supervisor #(
  parameter longint TICK_CYCLES = fsdo_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // staged settings in
  fsdo_cfg_if.dst         cfg,
  // link state
  input  wire logic       comm_lost,
  input  wire logic       host_write,
  // results
  output logic            in_failsafe,
  output logic [7:0]      act_kind,
  output logic [7:0]      act_bitmap,
  output logic [7:0]      act_delay
);

  fsdo_pkg::fsdo_sv_t state;
  logic [31:0]        pre_cnt;
  logic               tick;
  logic [7:0]         tenths;

  // ---------------------------------------------------------------------------
  // active settings, loaded only on commit
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      act_kind   <= fsdo_pkg::RST_KIND;
      act_bitmap <= fsdo_pkg::RST_BITMAP;
      act_delay  <= fsdo_pkg::RST_DELAY;
    end else if (cfg.commit) begin // [RL9]
      act_kind   <= cfg.kind;
      act_bitmap <= cfg.bitmap;
      act_delay  <= cfg.delay;
    end
  end

  // ---------------------------------------------------------------------------
  // prescaler: one-cycle tick every tenth of a second while delaying
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || state != fsdo_pkg::SV_DELAY) begin // [RL11]
      pre_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (pre_cnt == 32'(TICK_CYCLES - 1)) begin // [RL6]
      pre_cnt <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // supervisor: linked -> delay -> safe, or linked -> safe for delay 0; any host write returns to linked
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state  <= fsdo_pkg::SV_LINKED;
      tenths <= 8'h00;
    end else begin
      unique case (state)
        fsdo_pkg::SV_LINKED: begin
          tenths <= 8'h00;
          if (comm_lost) begin // [RL2] [RL8]
            state <= (act_delay == 8'h00) ? fsdo_pkg::SV_SAFE : fsdo_pkg::SV_DELAY; // [RL7]
          end
        end
        fsdo_pkg::SV_DELAY: begin
          if (host_write || !comm_lost) begin // [RL11]
            state <= fsdo_pkg::SV_LINKED;
          end else if (tick) begin
            tenths <= tenths + 8'h01;
            if (tenths + 8'h01 >= act_delay) begin // [RL7] [RL8]
              state <= fsdo_pkg::SV_SAFE;
            end
          end
        end
        fsdo_pkg::SV_SAFE: begin
          if (host_write) begin // [RL12]
            state <= fsdo_pkg::SV_LINKED;
          end
        end
        default: state <= fsdo_pkg::SV_LINKED;
      endcase
    end
  end

  assign in_failsafe = (state == fsdo_pkg::SV_SAFE);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_zero_delay_safe: assert property (@(posedge clk) disable iff (srst) // [RL7]
    (state == fsdo_pkg::SV_LINKED && comm_lost && act_delay == 8'h00)
      |=> state == fsdo_pkg::SV_SAFE)
    else $error("zero delay did not engage fail-safe at once");
  a_delay_not_early: assert property (@(posedge clk) disable iff (srst) // [RL8]
    (state == fsdo_pkg::SV_DELAY && $past(state) == fsdo_pkg::SV_DELAY)
      |-> tenths < act_delay)
    else $error("delay count passed setting without engaging");
  a_commit_loads: assert property (@(posedge clk) disable iff (srst) // [RL9]
    cfg.commit |=> act_kind == $past(cfg.kind) && act_delay == $past(cfg.delay))
    else $error("commit did not load settings");
  a_staged_hold: assert property (@(posedge clk) disable iff (srst) // [RL9]
    !cfg.commit |=> $stable(act_kind) && $stable(act_bitmap) && $stable(act_delay))
    else $error("active settings changed without commit");
  a_write_leaves_safe: assert property (@(posedge clk) disable iff (srst) // [RL12]
    (state == fsdo_pkg::SV_SAFE && host_write) |=> state == fsdo_pkg::SV_LINKED)
    else $error("host write did not leave fail-safe");

endmodule
`default_nettype wire

// *** fsdo_tb.sv ***
// testbench: fail-safe output port driven through the host model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  localparam longint TICK = 10;       // short tenth-second tick keeps the run brief
  localparam int     SUP  = 50;       // supervision timeout in cycles
  logic clk;
  logic srst;
  logic [7:0] awaddr, araddr, points;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, failsafe_active;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] kinds [3] = '{8'h01, 8'h02, 8'h03};
  logic [7:0] safe_exp [3] = '{8'h00, 8'hbc, 8'h11};

  fsdo_port #(.TICK_CYCLES(TICK)) u_dut (
    .clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .points(points), .failsafe_active(failsafe_active));

  fsdo_host_model u_host (
    .clk(clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // write expecting an okay answer
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rsp;
    u_host.wr(a, d, rsp);
    `CHK(rsp, fsdo_pkg::RESP_OKAY)
  endtask

  // read and compare data and answer code
  task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  rr;
    u_host.rd(a, d, rr);
    `CHK(d, e)
    `CHK(rr, er)
  endtask

  // silent host: count edges until fail-safe shows, must land inside [lo, hi)
  task automatic wait_safe(input int lo, input int hi);
    int n;
    n = 0;
    while (failsafe_active !== 1'b1 && n < hi) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= lo && n < hi, 1'b1)
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20000 * 8);
    n_mismatch++;
    complete_run();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK(points, 8'h00)
    `CHK(failsafe_active, 1'b0)
    r(fsdo_pkg::ADDR_STATUS, 32'h0000_0100, fsdo_pkg::RESP_OKAY);
    r(fsdo_pkg::ADDR_FAILSAFE_KIND, 32'h0, fsdo_pkg::RESP_OKAY);
    r(8'h20, 32'h0, fsdo_pkg::RESP_SLVERR);
    $display("test reset done");
    w(fsdo_pkg::ADDR_SUPERVISION, SUP);
    r(fsdo_pkg::ADDR_SUPERVISION, SUP, fsdo_pkg::RESP_OKAY);
    w(fsdo_pkg::ADDR_OUTPUT_POINTS, 32'h0000_00ff);
    r(fsdo_pkg::ADDR_OUTPUT_POINTS, 32'h0000_00ff, fsdo_pkg::RESP_OKAY);
    `CHK(points, 8'hff)
    $display("test points done");
    // staged values must not act until a true commit
    w(fsdo_pkg::ADDR_FAILSAFE_KIND, 32'h2);
    w(fsdo_pkg::ADDR_FAILSAFE_BITMAP, 32'h3c);
    w(fsdo_pkg::ADDR_FAILSAFE_DELAY, 32'h3);
    w(fsdo_pkg::ADDR_FAILSAFE_COMMIT, 32'h0);
    repeat (2) @(posedge clk);
    r(fsdo_pkg::ADDR_STATUS, 32'h0000_0100, fsdo_pkg::RESP_OKAY);
    w(fsdo_pkg::ADDR_FAILSAFE_COMMIT, 32'h1);
    repeat (2) @(posedge clk);
    r(fsdo_pkg::ADDR_STATUS, 32'h0003_0200, fsdo_pkg::RESP_OKAY);
    r(fsdo_pkg::ADDR_FAILSAFE_COMMIT, 32'h0, fsdo_pkg::RESP_OKAY);
    $display("test commit done");
    // loss with three tenths of delay, bitmap kind
    w(fsdo_pkg::ADDR_OUTPUT_POINTS, 32'h11);
    wait_safe(SUP - 5 + 2 * TICK, SUP + 3 * TICK + 8);
    `CHK(points, 8'h3c)
    w(fsdo_pkg::ADDR_OUTPUT_POINTS, 32'h11);
    @(posedge clk);
    `CHK(failsafe_active, 1'b0)
    `CHK(points, 8'h11)
    $display("test delayed loss done");
    // per-point write: point 7 on, the others keep their word value
    w(fsdo_pkg::ADDR_BITMAP_POINT, 32'h0000_0107);
    w(fsdo_pkg::ADDR_FAILSAFE_DELAY, 32'h0);
    for (int i = 0; i < 3; i++) begin
      w(fsdo_pkg::ADDR_FAILSAFE_KIND, {24'h0, kinds[i]});
      w(fsdo_pkg::ADDR_FAILSAFE_COMMIT, 32'h1);
      wait_safe(SUP - 5, SUP + 8);
      `CHK(points, safe_exp[i])
      w(fsdo_pkg::ADDR_OUTPUT_POINTS, 32'h11);
      @(posedge clk);
      `CHK(points, 8'h11)
    end
    $display("test kinds done");
    complete_run();
  end
endmodule
`default_nettype wire
